// file: rtl/coa_alu.sv
// combinational two-source alu used by every addressing mode except memory move and the indirect modes
`timescale 1ns/100ps
module coa_alu
  import coa_pkg::*;
(
  input  wire logic [2:0] op,
  input  wire logic [7:0] src_a,
  input  wire logic [7:0] src_b,
  output logic      [7:0] result
);
  // 0 move, 1 add, 2 sub, 3 and, 4 or, 5 xor; others pass src_b
  always_comb begin
    unique case (op)
      3'h0:    result = src_b;
      3'h1:    result = src_a + src_b;
      3'h2:    result = src_a - src_b;
      3'h3:    result = src_a & src_b;
      3'h4:    result = src_a | src_b;
      3'h5:    result = src_a ^ src_b;
      default: result = src_b;
    endcase
  end
endmodule

// file: rtl/coa_core.sv
// operand addressing sequencer: fetch operands, form addresses, place results
`timescale 1ns/100ps
module coa_core
  import coa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [3:0]  mode,
  input  wire logic [2:0]  alu_op,
  input  wire logic [1:0]  reg_sel,
  input  wire logic        reg_space,
  input  wire logic [7:0]  prog_data,
  input  wire logic [7:0]  mem_rdata,
  output logic             busy,
  output logic             done,
  output logic             prog_req,
  output logic      [7:0]  instr_pointer_high,
  output logic      [7:0]  instr_pointer_low,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic             mem_reg_space,
  output logic      [7:0]  mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  acc,
  output logic      [7:0]  flags,
  output logic      [7:0]  stack_pointer,
  output logic      [7:0]  index_reg
);
  coa_state_t state;
  coa_state_t next_state;
  coa_mode_t  cur_mode;
  coa_mode_t  next_cur_mode;
  logic [2:0] op_q;
  logic [2:0] next_op_q;
  logic [1:0] sel_q;
  logic [1:0] next_sel_q;
  logic       space_q;
  logic       next_space_q;
  logic [7:0] opnd1;
  logic [7:0] next_opnd1;
  logic [7:0] opnd2;
  logic [7:0] next_opnd2;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [7:0] next_acc;
  logic [7:0] next_flags;
  logic [7:0] next_stack_pointer;
  logic [7:0] next_index_reg;
  logic       next_busy;
  logic       next_done;
  logic       next_prog_req;
  logic       next_mem_rd;
  logic       next_mem_wr;
  logic       next_mem_reg_space;
  logic [7:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic       pc_step;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_y;

  // operand plus index, carry thrown away
  function automatic logic [7:0] idx_addr(input logic [7:0] base, input logic [7:0] x);
    logic [8:0] sum;
    sum = {1'b0, base} + {1'b0, x};
    return sum[7:0];
  endfunction

  // register picked by the opcode's register field
  function automatic logic [7:0] pick_reg(input logic [1:0] s, input logic [7:0] a,
                                          input logic [7:0] f, input logic [7:0] sp,
                                          input logic [7:0] x);
    logic [7:0] v;
    v = a;
    if (s == COA_REG_FLAGS) v = f;
    if (s == COA_REG_SP)    v = sp;
    if (s == COA_REG_IDX)   v = x;
    return v;
  endfunction

  function automatic logic three_byte(input coa_mode_t m);
    return (m == COA_DST_DIR_IMM) || (m == COA_DST_IDX_IMM) || (m == COA_MEM_MOVE);
  endfunction

  coa_pc u_pc (
    .clk                (clk),
    .rst_b              (rst_b),
    .step               (pc_step),
    .instr_pointer_high (instr_pointer_high),
    .instr_pointer_low  (instr_pointer_low)
  );

  coa_alu u_alu (
    .op     (op_q),
    .src_a  (alu_a),
    .src_b  (alu_b),
    .result (alu_y)
  );

  // alu sources per mode: destination modes use memory contents as first source
  always_comb begin
    alu_a = pick_reg(sel_q, acc, flags, stack_pointer, index_reg);
    alu_b = rdata;
    unique case (cur_mode)
      COA_SRC_IMM:                   alu_b = opnd1;
      COA_DST_DIR:                   alu_a = rdata;
      COA_DST_IDX:                   begin alu_a = rdata; alu_b = acc; end
      COA_DST_DIR_IMM, COA_DST_IDX_IMM: begin alu_a = rdata; alu_b = opnd2; end
      default:                       alu_a = pick_reg(sel_q, acc, flags, stack_pointer, index_reg);
    endcase
    if (cur_mode == COA_DST_DIR) alu_b = pick_reg(sel_q, acc, flags, stack_pointer, index_reg);
  end

  // pc advances once for each program byte taken
  assign pc_step = prog_req;

  // sequencer: opcode taken at start, then one state per byte or access
  always_comb begin
    next_state         = state;
    next_cur_mode      = cur_mode;
    next_op_q          = op_q;
    next_sel_q         = sel_q;
    next_space_q       = space_q;
    next_opnd1         = opnd1;
    next_opnd2         = opnd2;
    next_rdata         = rdata;
    next_ptr           = ptr;
    next_acc           = acc;
    next_flags         = flags;
    next_stack_pointer = stack_pointer;
    next_index_reg     = index_reg;
    next_busy          = 1'b1;
    next_done          = 1'b0;
    next_prog_req      = 1'b0;
    next_mem_rd        = 1'b0;
    next_mem_wr        = 1'b0;
    next_mem_reg_space = space_q;
    next_mem_addr      = mem_addr;
    next_mem_wdata     = mem_wdata;
    unique case (state)
      COA_ST_IDLE: begin
        next_busy = 1'b0;
        if (start) begin
          next_cur_mode = coa_mode_t'(mode);
          next_op_q     = alu_op;
          next_sel_q    = reg_sel;
          // memory move and indirect modes work in ram only
          next_space_q  = reg_space && (mode < COA_MEM_MOVE);
          next_prog_req = 1'b1;    // operand 1 byte follows
          next_busy     = 1'b1;
          next_state    = COA_ST_OP1;
        end
      end
      COA_ST_OP1: begin
        next_opnd1 = prog_data;
        if (three_byte(cur_mode)) begin
          next_prog_req = 1'b1;
          next_state    = COA_ST_OP2;
        end else if (cur_mode == COA_SRC_IMM) begin
          next_state = COA_ST_EXEC;
        end else begin
          next_mem_rd   = 1'b1;
          next_mem_addr = prog_data;
          if (cur_mode == COA_SRC_IDX || cur_mode == COA_DST_IDX)
            next_mem_addr = idx_addr(prog_data, index_reg);
          next_state = (cur_mode >= COA_IND_SRC_INC) ? COA_ST_PTR : COA_ST_RD;
        end
      end
      COA_ST_OP2: begin
        next_opnd2  = prog_data;
        next_mem_rd = 1'b1;
        unique case (cur_mode)
          COA_MEM_MOVE:    next_mem_addr = prog_data;
          COA_DST_IDX_IMM: next_mem_addr = idx_addr(opnd1, index_reg);
          default:         next_mem_addr = opnd1;
        endcase
        next_state = COA_ST_RD;
      end
      COA_ST_PTR: begin
        // pointer fetched; now access the location it names
        next_ptr      = mem_rdata;
        next_mem_addr = mem_rdata;
        if (cur_mode == COA_IND_SRC_INC) begin
          next_mem_rd = 1'b1;
          next_state  = COA_ST_RD;
        end else begin
          next_mem_wr    = 1'b1;
          next_mem_wdata = acc;
          next_state     = COA_ST_INC;
        end
      end
      COA_ST_RD: begin
        next_rdata = mem_rdata;
        next_state = COA_ST_EXEC;
      end
      COA_ST_EXEC: begin
        next_done  = 1'b1;
        next_state = COA_ST_IDLE;
        unique case (cur_mode)
          COA_SRC_IMM: begin
            // immediate result may land in any of the four registers
            unique case (coa_reg_t'(sel_q))
              COA_REG_ACC:   next_acc           = alu_y;
              COA_REG_FLAGS: next_flags         = alu_y;
              COA_REG_SP:    next_stack_pointer = alu_y;
              COA_REG_IDX:   next_index_reg     = alu_y;
            endcase
          end
          COA_SRC_DIR, COA_SRC_IDX: begin
            // memory sources only reach acc or index; a flags or sp select falls back to acc
            if (sel_q == COA_REG_IDX) begin
              next_index_reg = alu_y;
            end else begin
              next_acc = alu_y;
            end
          end
          COA_IND_SRC_INC: begin
            next_acc       = rdata;
            next_mem_wr    = 1'b1;
            next_mem_addr  = opnd1;
            next_mem_wdata = ptr + COA_PTR_STEP;
          end
          COA_MEM_MOVE: begin
            next_mem_wr    = 1'b1;
            next_mem_addr  = opnd1;
            next_mem_wdata = rdata;
          end
          default: begin
            // destination modes write back; source register untouched
            next_mem_wr    = 1'b1;
            next_mem_wdata = alu_y;
          end
        endcase
      end
      COA_ST_INC: begin
        next_mem_wr    = 1'b1;
        next_mem_addr  = opnd1;
        next_mem_wdata = ptr + COA_PTR_STEP;
        next_done      = 1'b1;
        next_state     = COA_ST_IDLE;
      end
      default: next_state = COA_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= COA_ST_IDLE;
      cur_mode      <= COA_SRC_IMM;
      op_q          <= 3'h0;
      sel_q         <= 2'h0;
      space_q       <= 1'b0;
      opnd1         <= COA_RST_BYTE;
      opnd2         <= COA_RST_BYTE;
      rdata         <= COA_RST_BYTE;
      ptr           <= COA_RST_BYTE;
      acc           <= COA_RST_BYTE;
      flags         <= COA_RST_BYTE;
      stack_pointer <= COA_RST_BYTE;
      index_reg     <= COA_RST_BYTE;
      busy          <= 1'b0;
      done          <= 1'b0;
      prog_req      <= 1'b0;
      mem_rd        <= 1'b0;
      mem_wr        <= 1'b0;
      mem_reg_space <= 1'b0;
      mem_addr      <= COA_RST_BYTE;
      mem_wdata     <= COA_RST_BYTE;
    end else begin
      state         <= next_state;
      cur_mode      <= next_cur_mode;
      op_q          <= next_op_q;
      sel_q         <= next_sel_q;
      space_q       <= next_space_q;
      opnd1         <= next_opnd1;
      opnd2         <= next_opnd2;
      rdata         <= next_rdata;
      ptr           <= next_ptr;
      acc           <= next_acc;
      flags         <= next_flags;
      stack_pointer <= next_stack_pointer;
      index_reg     <= next_index_reg;
      busy          <= next_busy;
      done          <= next_done;
      prog_req      <= next_prog_req;
      mem_rd        <= next_mem_rd;
      mem_wr        <= next_mem_wr;
      mem_reg_space <= next_mem_reg_space;
      mem_addr      <= next_mem_addr;
      mem_wdata     <= next_mem_wdata;
    end
  end
endmodule

// file: rtl/coa_pc.sv
// split instruction pointer, high and low byte holders
`timescale 1ns/100ps
module coa_pc
  import coa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        step,
  output logic      [7:0]  instr_pointer_high,
  output logic      [7:0]  instr_pointer_low
);
  logic [7:0] next_instr_pointer_high;
  logic [7:0] next_instr_pointer_low;

  // carry out of the low byte ripples into the high byte
  always_comb begin
    {next_instr_pointer_high, next_instr_pointer_low} =
      {instr_pointer_high, instr_pointer_low};
    if (step) begin
      {next_instr_pointer_high, next_instr_pointer_low} =
        {instr_pointer_high, instr_pointer_low} + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_pointer_high <= COA_RST_BYTE;
      instr_pointer_low  <= COA_RST_BYTE;
    end else begin
      instr_pointer_high <= next_instr_pointer_high;
      instr_pointer_low  <= next_instr_pointer_low;
    end
  end
endmodule

// file: rtl/coa_pkg.sv
// constants and types for the operand addressing block
package coa_pkg;
  localparam int unsigned COA_DW          = 8;
  localparam logic [7:0]  COA_RST_BYTE    = 8'h00;
  localparam logic [15:0] COA_RST_PTR     = 16'h0000;
  localparam logic [1:0]  COA_LEN_TWO     = 2'h2;
  localparam logic [1:0]  COA_LEN_THREE   = 2'h3;
  localparam logic [7:0]  COA_PTR_STEP    = 8'h01;

  // addressing modes, selected by the opcode decoder outside this block
  typedef enum logic [3:0] {
    COA_SRC_IMM      = 4'h0,
    COA_SRC_DIR      = 4'h1,
    COA_SRC_IDX      = 4'h2,
    COA_DST_DIR      = 4'h3,
    COA_DST_IDX      = 4'h4,
    COA_DST_DIR_IMM  = 4'h5,
    COA_DST_IDX_IMM  = 4'h6,
    COA_MEM_MOVE     = 4'h7,
    COA_IND_SRC_INC  = 4'h8,
    COA_IND_DST_INC  = 4'h9
  } coa_mode_t;

  // register selected as source or destination
  typedef enum logic [1:0] {
    COA_REG_ACC   = 2'h0,
    COA_REG_FLAGS = 2'h1,
    COA_REG_SP    = 2'h2,
    COA_REG_IDX   = 2'h3
  } coa_reg_t;

  // sequencer states, gray coded along the fetch path
  typedef enum logic [2:0] {
    COA_ST_IDLE  = 3'b000,
    COA_ST_OP1   = 3'b001,
    COA_ST_OP2   = 3'b011,
    COA_ST_RD    = 3'b010,
    COA_ST_PTR   = 3'b110,
    COA_ST_EXEC  = 3'b111,
    COA_ST_INC   = 3'b101
  } coa_state_t;
endpackage

// file: tb/coa_core_asserts.sv
// concurrent checks on the operand addressing sequencer ports
`timescale 1ns/100ps
module coa_core_asserts
  import coa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [3:0]  mode,
  input  wire logic        prog_req,
  input  wire logic [7:0]  prog_data,
  input  wire logic        busy,
  input  wire logic        done,
  input  wire logic [7:0]  instr_pointer_high,
  input  wire logic [7:0]  instr_pointer_low,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_reg_space,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  index_reg
);
  logic [3:0] cur_mode;
  logic [7:0] op1;
  logic [1:0] nbytes;

  // mode of the running instruction, its first operand and its operand count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_mode <= 4'h0;
      op1      <= 8'h00;
      nbytes   <= 2'h0;
    end else if (start && (!busy || done)) begin // the done cycle is already idle
      cur_mode <= mode;
      nbytes   <= 2'h0;
    end else if (prog_req) begin
      nbytes <= nbytes + 2'h1;
      if (nbytes == 2'h0) begin
        op1 <= prog_data;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_done_pulse: assert property (done |=> !done)
    else $error("done pulse lasted more than one cycle");
  a_done_bound: assert property ($rose(busy) |-> ##[1:5] done)
    else $error("instruction did not finish in time");
  a_reset_zero: assert property ($rose(rst_b) |->
    {instr_pointer_high, instr_pointer_low, index_reg} == 24'h000000)
    else $error("pointer or index not zero after reset");
  a_pc_step: assert property ($changed({instr_pointer_high, instr_pointer_low}) |->
    {instr_pointer_high, instr_pointer_low} == $past({instr_pointer_high, instr_pointer_low})
    + 16'h0001)
    else $error("instruction pointer moved by other than one");
  a_idx_addr: assert property (mem_rd && cur_mode == COA_SRC_IDX |->
    mem_addr == 8'(op1 + index_reg))
    else $error("indexed source address wrong");
  a_dst_addr: assert property (mem_wr && cur_mode == COA_DST_DIR |-> mem_addr == op1)
    else $error("direct destination address wrong");
  a_acc_kept: assert property (busy && cur_mode == COA_DST_DIR |=> $stable(acc))
    else $error("accumulator changed in destination mode");
  a_len_count: assert property (done |-> nbytes ==
    ((cur_mode inside {COA_DST_DIR_IMM, COA_DST_IDX_IMM, COA_MEM_MOVE}) ? 2'h2 : 2'h1))
    else $error("operand byte count wrong");
  a_ram_only: assert property ((mem_rd || mem_wr) &&
    cur_mode inside {COA_MEM_MOVE, COA_IND_SRC_INC, COA_IND_DST_INC} |-> !mem_reg_space)
    else $error("register space used by a ram only mode");

  c_move: cover property (done && cur_mode == COA_MEM_MOVE);
  c_ind_dst: cover property (done && cur_mode == COA_IND_DST_INC);
  c_idx_imm: cover property (done && cur_mode == COA_DST_IDX_IMM);
endmodule

// file: tb/coa_mem_model.sv
// program memory, data ram and register space seen by the sequencer
`timescale 1ns/100ps
module coa_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        prog_req,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic        mem_reg_space,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  prog_data,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] rom [256];
  logic [7:0] ram [256];
  logic [7:0] regs [256];
  logic [7:0] ptr;
  logic [7:0] plast;
  logic [7:0] last;
  logic       pr_d;
  logic       rd_d;
  logic [7:0] val;

  // byte shown in the request cycle, held one more, then inverted so stale use shows
  assign val       = mem_reg_space ? regs[mem_addr] : ram[mem_addr];
  assign prog_data = prog_req ? rom[ptr] : (pr_d ? plast : ~plast);
  assign mem_rdata = mem_rd ? val : (rd_d ? last : ~last);

  // plain always: the bench also preloads these arrays
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr   <= 8'h00;
      pr_d  <= 1'b0;
      rd_d  <= 1'b0;
      plast <= 8'h00;
      last  <= 8'h00;
    end else begin
      pr_d <= prog_req;
      rd_d <= mem_rd;
      if (prog_req) begin
        plast <= rom[ptr];
        ptr   <= ptr + 8'h01;
      end
      if (mem_rd) last <= val;
      if (mem_wr && mem_reg_space) regs[mem_addr] <= mem_wdata;
      if (mem_wr && !mem_reg_space) ram[mem_addr] <= mem_wdata;
    end
  end
endmodule

// file: tb/tb.sv
// self-checking bench for the operand addressing sequencer
`timescale 1ns/100ps
module tb;
  import coa_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic [3:0]  mode = 4'h0;
  logic [2:0]  alu_op = 3'h0;
  logic [1:0]  reg_sel = 2'h0;
  logic        reg_space = 1'b0;
  logic [7:0]  prog_data, mem_rdata, instr_pointer_high, instr_pointer_low;
  logic [7:0]  mem_addr, mem_wdata, acc, flags, stack_pointer, index_reg;
  logic        busy, done, prog_req, mem_rd, mem_wr, mem_reg_space;
  int          errors = 0;
  int          checks_done = 0;
  logic [15:0] pc_exp = 16'h0000;

  always #4 clk = ~clk;

  coa_core dut_u (.clk, .rst_b, .start, .mode, .alu_op, .reg_sel, .reg_space, .prog_data,
    .mem_rdata, .busy, .done, .prog_req, .instr_pointer_high, .instr_pointer_low, .mem_rd,
    .mem_wr, .mem_reg_space, .mem_addr, .mem_wdata, .acc, .flags, .stack_pointer, .index_reg);
  coa_mem_model mdl (.clk, .rst_b, .prog_req, .mem_rd, .mem_wr, .mem_reg_space, .mem_addr,
    .mem_wdata, .prog_data, .mem_rdata);

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic test_done();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [7:0] reg_val(input int r);
    case (r)
      0: return acc;
      1: return flags;
      2: return stack_pointer;
      default: return index_reg;
    endcase
  endfunction

  // one instruction: load its operands, start it, wait for done, then check the pointer
  task automatic run(input logic [3:0] m, input logic [2:0] op, input logic [1:0] r,
                     input logic sp, input logic [7:0] b1, input logic [7:0] b2, input int nb);
    int n;
    mdl.rom[pc_exp[7:0]] = b1;
    mdl.rom[pc_exp[7:0] + 8'h01] = b2;
    mode = m;
    alu_op = op;
    reg_sel = r;
    reg_space = sp;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20) begin
      errors++;
      test_done();
    end
    // the final write lands on the edge after done
    @(posedge clk);
    #1 pc_exp = pc_exp + 16'(nb);
    chk("pc high", pc_exp[15:8], instr_pointer_high);
    chk("pc low", pc_exp[7:0], instr_pointer_low);
  endtask

  task automatic t_reset();
    chk("pc high", 8'h00, instr_pointer_high);
    chk("pc low", 8'h00, instr_pointer_low);
    chk("index", 8'h00, index_reg);
    chk("acc", 8'h00, acc);
  endtask

  task automatic t_imm();
    for (int r = 0; r < 4; r++) begin
      run(COA_SRC_IMM, 3'h0, r[1:0], 1'b0, 8'h50 + 8'(r), 8'h00, 1);
      chk("immediate dest", 8'h50 + 8'(r), reg_val(r));
    end
  endtask

  task automatic t_src();
    mdl.ram[8'h07] = 8'h05;
    run(COA_SRC_DIR, 3'h1, COA_REG_ACC, 1'b0, 8'h07, 8'h00, 1);
    chk("direct add", 8'h55, acc);
    run(COA_SRC_DIR, 3'h0, COA_REG_FLAGS, 1'b0, 8'h07, 8'h00, 1);
    chk("direct to acc", 8'h05, acc);
    chk("flags kept", 8'h51, flags);
    mdl.regs[8'h13] = 8'h3C;
    run(COA_SRC_IDX, 3'h0, COA_REG_ACC, 1'b1, 8'hC0, 8'h00, 1);
    chk("indexed src", 8'h3C, acc);
  endtask

  task automatic t_dst();
    mdl.ram[8'h20] = 8'h01;
    run(COA_DST_DIR, 3'h1, COA_REG_ACC, 1'b0, 8'h20, 8'h00, 1);
    chk("direct dest", 8'h3D, mdl.ram[8'h20]);
    chk("acc kept", 8'h3C, acc);
    mdl.regs[8'h03] = 8'h00;
    run(COA_DST_IDX, 3'h0, COA_REG_ACC, 1'b1, 8'hB0, 8'h00, 1);
    chk("indexed dest", 8'h3C, mdl.regs[8'h03]);
    mdl.ram[8'h21] = 8'h10;
    run(COA_DST_DIR_IMM, 3'h1, COA_REG_ACC, 1'b0, 8'h21, 8'h22, 2);
    chk("direct imm", 8'h32, mdl.ram[8'h21]);
    mdl.regs[8'h63] = 8'h0F;
    run(COA_DST_IDX_IMM, 3'h5, COA_REG_ACC, 1'b1, 8'h10, 8'hF0, 2);
    chk("indexed imm", 8'hFF, mdl.regs[8'h63]);
  endtask

  task automatic t_move_ind();
    mdl.ram[8'h40] = 8'hA5;
    run(COA_MEM_MOVE, 3'h0, COA_REG_ACC, 1'b0, 8'h41, 8'h40, 2);
    chk("mem move", 8'hA5, mdl.ram[8'h41]);
    mdl.ram[8'h08] = 8'h30;
    mdl.ram[8'h30] = 8'h77;
    run(COA_IND_SRC_INC, 3'h0, COA_REG_ACC, 1'b0, 8'h08, 8'h00, 1);
    chk("indirect load", 8'h77, acc);
    chk("pointer inc", 8'h31, mdl.ram[8'h08]);
    mdl.ram[8'h31] = 8'h00;
    run(COA_IND_DST_INC, 3'h0, COA_REG_ACC, 1'b0, 8'h08, 8'h00, 1);
    chk("indirect store", 8'h77, mdl.ram[8'h31]);
    chk("pointer inc", 8'h32, mdl.ram[8'h08]);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_imm();
    t_src();
    t_dst();
    t_move_ind();
    test_done();
  end
endmodule

bind coa_core coa_core_asserts chk_u (.clk, .rst_b, .start, .mode, .prog_req, .prog_data,
  .busy, .done, .instr_pointer_high, .instr_pointer_low, .mem_rd, .mem_wr, .mem_reg_space,
  .mem_addr, .acc, .index_reg);
